//--- common/dafc_map.vh
// Constants for the DSP-side AC-link FIFO control block.
// Assumes inclusion by the core files only; holds definitions alone.
`ifndef DAFC_MAP_VH
`define DAFC_MAP_VH
// ----------------------------------------
// Control register field positions
// ----------------------------------------
`define DAFC_LINK_LO 0
`define DAFC_LINK_HI 1
`define DAFC_RSVD_BIT 2
`define DAFC_STEREO_BIT 3
`define DAFC_SLOT_LO 4
`define DAFC_SLOT_HI 7
`define DAFC_LVL_LO 8
`define DAFC_LVL_HI 10
`define DAFC_DMA_BIT 11
`define DAFC_FULL_BIT 13
`define DAFC_EMPTY_BIT 14
`define DAFC_ERR_BIT 15
// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define DAFC_LINK_OFF 2'h0
`define DAFC_LINK_AC 2'h2
`define DAFC_SLOT_MIN 4'h3
`define DAFC_SLOT_MAX 4'hC
`define DAFC_CTRL_RESET 16'h0000
`define DAFC_WMASK 16'h0FFB
`endif

//--- core/dafc_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module dafc_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire srst,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data,
  output wire [AW:0] count
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg [AW:0] used;
  wire do_wr;
  wire do_rd;
  wire load;
  // ----------------------------------------
  // Handshake
  // ----------------------------------------
  // The output register is a one-word stage; count covers both storage and stage.
  // Room is judged on the total including the stage, so the FIFO never holds more than DEPTH words.
  assign in_ready = (count < DEPTH[AW:0]);
  assign load = (used != {(AW+1){1'b0}}) && (!out_valid || out_ready);
  assign do_wr = in_valid && in_ready;
  assign do_rd = load;
  assign count = used + {{AW{1'b0}}, out_valid};
  // ----------------------------------------
  // Storage and pointers
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (do_wr)
      mem[wptr] <= in_data;
  end
  // Pointer and stage update; flush empties everything at once.
  always @(posedge clk)
  begin
    if (srst || flush)
    begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      used <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end
    else
    begin
      if (do_wr)
        wptr <= (wptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr + 1'b1;
      if (do_rd)
      begin
        rptr <= (rptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr + 1'b1;
        out_data <= mem[rptr];
        out_valid <= 1'b1;
      end
      else if (out_ready)
        out_valid <= 1'b0;
      used <= used + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end
endmodule // dafc_fifo

//--- core/dafc_link_fifo.v
// Transmit and receive FIFO pair with control registers between DSP core and AC-link slot logic.
// Assumes slot logic in the same clock domain presenting one request or word per cycle.
`include "dafc_map.vh"
// Operation
// - Link field 00 disables FIFO, 10 attaches it to AC-link, others reserved.
// - Bit 3 picks mono (0) or stereo (1) in AC-link mode.
// - Slot field bits 7..4 codes 3..12 name slots directly; others reserved.
// - Stereo serves chosen slot and next; software avoids stereo with slot 12.
// - Stereo samples alternate left then right in the FIFO.
// - Transmit slot request while empty sets underflow at bit 15; data invalid.
// - Receive word while full is dropped and sets overflow at bit 15.
// - Error flags stick until software writes one; zero leaves them.
// - Transmit interrupt level while words remaining equals threshold bits 10..8.
// - Receive interrupt level once received words reach threshold plus one.
// - Bit 11 enables DMA requests; clear means no DMA request.
// - Transmit register shows full at bit 13, empty at bit 14.
// - Receive register shows full at bit 13, empty at bit 14.
// - Each FIFO holds eight sixteen-bit entries.
// - Each FIFO can raise DMA requests to move data.
module dafc_link_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire srst,
  input wire tx_ctrl_wr,
  input wire rx_ctrl_wr,
  input wire [15:0] ctrl_wdata,
  output wire [15:0] tx_fifo_control,
  output wire [15:0] rx_fifo_control,
  input wire tx_data_valid,
  output wire tx_data_ready,
  input wire [WIDTH-1:0] tx_data,
  output wire rx_data_valid,
  input wire rx_data_ready,
  output wire [WIDTH-1:0] rx_data,
  input wire [3:0] slot_num,
  input wire tx_slot_req,
  output reg [WIDTH-1:0] tx_slot_data,
  output reg tx_slot_valid,
  input wire rx_slot_valid,
  input wire [WIDTH-1:0] rx_slot_data,
  output wire tx_irq,
  output wire rx_irq,
  output wire tx_dma_req,
  output wire rx_dma_req
);
  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // True when this slot belongs to the FIFO under the given settings.
  function slot_hit;
    input [15:0] ctrl;
    input [3:0] slot;
    reg [3:0] base;
    begin
      base = ctrl[`DAFC_SLOT_HI:`DAFC_SLOT_LO];
      slot_hit = (ctrl[`DAFC_LINK_HI:`DAFC_LINK_LO] == `DAFC_LINK_AC) &&
        (base >= `DAFC_SLOT_MIN) && (base <= `DAFC_SLOT_MAX) &&
        ((slot == base) || (ctrl[`DAFC_STEREO_BIT] && (slot == base + 4'h1)));
    end
  endfunction
  // Merges a software write into the control register.
  function [15:0] merge_ctrl;
    input [15:0] old;
    input [15:0] wdat;
    begin
      merge_ctrl = (old & ~`DAFC_WMASK) | (wdat & `DAFC_WMASK);
      merge_ctrl[`DAFC_RSVD_BIT] = 1'b0;
    end
  endfunction
  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  reg [15:0] tx_cfg;
  reg [15:0] rx_cfg;
  reg tx_underflow;
  reg rx_overflow;
  wire [AW:0] tx_count;
  wire [AW:0] rx_count;
  wire tx_hit;
  wire rx_hit;
  wire tx_out_valid;
  wire [WIDTH-1:0] tx_out_data;
  wire rx_in_ready;
  wire tx_under_evt;
  wire rx_over_evt;
  wire tx_full_flag;
  wire tx_empty_flag;
  wire rx_full_flag;
  wire rx_empty_flag;
  wire [2:0] tx_lvl;
  wire [2:0] rx_lvl;
  // Configuration bits; reserved bit forced low so a stray write cannot stick.
  always @(posedge clk)
  begin
    if (srst)
    begin
      tx_cfg <= `DAFC_CTRL_RESET;
      rx_cfg <= `DAFC_CTRL_RESET;
    end
    else
    begin
      if (tx_ctrl_wr)
        tx_cfg <= merge_ctrl(tx_cfg, ctrl_wdata);
      if (rx_ctrl_wr)
        rx_cfg <= merge_ctrl(rx_cfg, ctrl_wdata);
    end
  end
  // ----------------------------------------
  // Slot matching and error events
  // ----------------------------------------
  // Slots arrive in order, so a stereo pair lands left then right naturally.
  assign tx_hit = tx_slot_req && slot_hit(tx_cfg, slot_num);
  assign rx_hit = rx_slot_valid && slot_hit(rx_cfg, slot_num);
  assign tx_under_evt = tx_hit && !tx_out_valid;
  assign rx_over_evt = rx_hit && !rx_in_ready;
  // Sticky flags; a new event in the clearing cycle wins over the clear.
  always @(posedge clk)
  begin
    if (srst)
    begin
      tx_underflow <= 1'b0;
      rx_overflow <= 1'b0;
    end
    else
    begin
      tx_underflow <= tx_under_evt ||
        (tx_underflow && !(tx_ctrl_wr && ctrl_wdata[`DAFC_ERR_BIT]));
      rx_overflow <= rx_over_evt ||
        (rx_overflow && !(rx_ctrl_wr && ctrl_wdata[`DAFC_ERR_BIT]));
    end
  end
  // ----------------------------------------
  // Transmit slot data
  // ----------------------------------------
  // On underflow the slot still gets a word, marked invalid and zeroed.
  always @(posedge clk)
  begin
    if (srst)
    begin
      tx_slot_data <= {WIDTH{1'b0}};
      tx_slot_valid <= 1'b0;
    end
    else
    begin
      tx_slot_valid <= tx_hit && tx_out_valid;
      if (tx_hit)
        tx_slot_data <= tx_out_valid ? tx_out_data : {WIDTH{1'b0}};
    end
  end
  // ----------------------------------------
  // FIFOs
  // ----------------------------------------
  // Disabling a FIFO flushes it so stale samples never reach a new slot.
  dafc_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_tx_fifo (
    .clk(clk),
    .srst(srst),
    .flush(tx_cfg[`DAFC_LINK_HI:`DAFC_LINK_LO] == `DAFC_LINK_OFF),
    .in_valid(tx_data_valid),
    .in_ready(tx_data_ready),
    .in_data(tx_data),
    .out_valid(tx_out_valid),
    .out_ready(tx_hit),
    .out_data(tx_out_data),
    .count(tx_count)
  );
  dafc_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_rx_fifo (
    .clk(clk),
    .srst(srst),
    .flush(rx_cfg[`DAFC_LINK_HI:`DAFC_LINK_LO] == `DAFC_LINK_OFF),
    .in_valid(rx_hit),
    .in_ready(rx_in_ready),
    .in_data(rx_slot_data),
    .out_valid(rx_data_valid),
    .out_ready(rx_data_ready),
    .out_data(rx_data),
    .count(rx_count)
  );
  // ----------------------------------------
  // Status, interrupts and DMA requests
  // ----------------------------------------
  assign tx_full_flag = (tx_count == DEPTH[AW:0]);
  assign tx_empty_flag = (tx_count == {(AW+1){1'b0}});
  assign rx_full_flag = (rx_count == DEPTH[AW:0]);
  assign rx_empty_flag = (rx_count == {(AW+1){1'b0}});
  assign tx_lvl = tx_cfg[`DAFC_LVL_HI:`DAFC_LVL_LO];
  assign rx_lvl = rx_cfg[`DAFC_LVL_HI:`DAFC_LVL_LO];
  assign tx_irq = (tx_count == {1'b0, tx_lvl});
  assign rx_irq = (rx_count >= ({1'b0, rx_lvl} + 4'h1));
  // DMA asks for a word while there is room, or drains while data waits.
  assign tx_dma_req = tx_cfg[`DAFC_DMA_BIT] && !tx_full_flag;
  assign rx_dma_req = rx_cfg[`DAFC_DMA_BIT] && !rx_empty_flag;
  // Read views of both control registers.
  assign tx_fifo_control = {tx_underflow, tx_empty_flag, tx_full_flag, 1'b0,
    tx_cfg[`DAFC_DMA_BIT:`DAFC_LINK_LO]};
  assign rx_fifo_control = {rx_overflow, rx_empty_flag, rx_full_flag, 1'b0,
    rx_cfg[`DAFC_DMA_BIT:`DAFC_LINK_LO]};
endmodule // dafc_link_fifo

//--- sim/dafc_slot_model.sv
// Slot-side model of the AC-link frame logic.
// Assumes the clock of the block it faces.
module dafc_slot_model (
  input wire logic clk,
  output logic [3:0] slot_num = 4'h0,
  output logic tx_slot_req = 1'b0,
  output logic rx_slot_valid = 1'b0,
  output logic [15:0] rx_slot_data = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  // One slot event held over one edge; released data is inverted so it never looks fresh.
  task automatic slot(input bit rx, input logic [3:0] n, input logic [15:0] d);
    @(posedge clk);
    #1;
    slot_num = n;
    tx_slot_req = !rx;
    rx_slot_valid = rx;
    rx_slot_data = d;
    @(posedge clk);
    #1;
    tx_slot_req = 1'b0;
    rx_slot_valid = 1'b0;
    rx_slot_data = ~d;
  endtask
endmodule // dafc_slot_model

//--- sim/dafc_link_fifo_properties.sv
// Concurrent checks on the ports of dafc_link_fifo.
// Assumes one clock and a synchronous active-high srst.
module dafc_link_fifo_properties (
  input wire logic clk,
  input wire logic srst,
  input wire logic tx_ctrl_wr,
  input wire logic [15:0] ctrl_wdata,
  input wire logic [15:0] tx_fifo_control,
  input wire logic [15:0] rx_fifo_control,
  input wire logic tx_data_ready,
  input wire logic [3:0] slot_num,
  input wire logic tx_slot_req,
  input wire logic tx_slot_valid,
  input wire logic rx_slot_valid,
  input wire logic tx_irq,
  input wire logic tx_dma_req
);
  // Slot hits rebuilt from the views, receive side on the chosen slot only, not the stereo partner; reserved codes never hit.
  wire [15:0] t = tx_fifo_control;
  wire [15:0] r = rx_fifo_control;
  wire tx_hit = tx_slot_req && t[1:0] == 2'h2 && t[7:4] > 4'h2 && t[7:4] < 4'hD
    && (slot_num == t[7:4] || (t[3] && slot_num == t[7:4] + 4'h1));
  wire rx_hit = rx_slot_valid && r[1:0] == 2'h2 && r[7:4] > 4'h2 && r[7:4] < 4'hD && slot_num == r[7:4];
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_reset_view: assert property ($fell(srst) |-> t == 16'h4000 && r == 16'h4000) else $error("bad view");
  a_underflow_set: assert property (tx_hit && t[14] |=> t[15] && !tx_slot_valid) else $error("no underflow");
  a_overflow_set: assert property (rx_hit && r[13] |=> r[15]) else $error("no overflow");
  a_flag_sticky: assert property (t[15] && !(tx_ctrl_wr && ctrl_wdata[15]) |=> t[15]) else $error("flag lost");
  a_flag_clear: assert property (tx_ctrl_wr && ctrl_wdata[15] && !tx_slot_req |=> !t[15]) else $error("kept");
  a_no_answer: assert property (!tx_hit |=> !tx_slot_valid) else $error("answer without hit");
  a_full_refuse: assert property (t[13] |-> !tx_data_ready) else $error("room while full");
  a_tx_irq_empty: assert property (t[14] |-> tx_irq == (t[10:8] == 3'h0)) else $error("bad irq");
  a_dma_off: assert property (!t[11] |-> !tx_dma_req) else $error("dma while off");
  c_underflow: cover property (tx_hit && t[14]);
  c_overflow: cover property (rx_hit && r[13]);
  c_stereo: cover property (tx_hit && t[3]);
endmodule // dafc_link_fifo_properties
bind dafc_link_fifo dafc_link_fifo_properties i_dafc_link_fifo_properties (.*);

//--- sim/dafc_link_fifo_tb.sv
// Self-checking bench for dafc_link_fifo with the slot-side model.
// Assumes a 125 MHz clock and reset held for 8 cycles.
module dafc_link_fifo_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, srst, tx_ctrl_wr, rx_ctrl_wr, tx_data_valid, rx_data_ready, tx_data_ready, rx_data_valid;
  logic tx_slot_req, tx_slot_valid, rx_slot_valid, tx_irq, rx_irq, tx_dma_req, rx_dma_req;
  logic [15:0] ctrl_wdata, tx_data, rx_data, tx_slot_data, rx_slot_data, tx_fifo_control, rx_fifo_control;
  logic [3:0] slot_num;
  int errors, compares;
  dafc_link_fifo i_dafc_link_fifo (.*);
  dafc_slot_model i_dafc_slot_model (.*);
  // Free-running clock.
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // Compare and count.
  task automatic check(string n, logic [15:0] s, logic [15:0] e);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  // Each strobe starts one edge late so it is never set twice in one step.
  task automatic wr(bit rx, logic [15:0] d);
    step;
    {rx_ctrl_wr, tx_ctrl_wr} = {rx, !rx};
    ctrl_wdata = d;
    step;
    {rx_ctrl_wr, tx_ctrl_wr} = 2'h0;
  endtask
  task automatic push(logic [15:0] d);
    step;
    tx_data = d;
    tx_data_valid = 1;
    step;
    tx_data_valid = 0;
  endtask
  task automatic t_mono;
    wr(0, 16'h0132);
    check("irq", 16'(tx_irq), 16'h0);
    push(16'h1234);
    step;
    check("irq", 16'(tx_irq), 16'h1);
    i_dafc_slot_model.slot(0, 4'h4, 16'h0);
    check("slot4", 16'(tx_slot_valid), 16'h0);
    i_dafc_slot_model.slot(0, 4'h3, 16'h0);
    check("valid", 16'(tx_slot_valid), 16'h1);
    check("mono", tx_slot_data, 16'h1234);
  endtask
  task automatic t_stereo;
    wr(0, 16'h08BA);
    check("dma", 16'(tx_dma_req), 16'h1);
    for (int i = 0; i < 8; i++)
      push(16'hA000 + 16'(i));
    check("ready", 16'(tx_data_ready), 16'h0);
    check("full", tx_fifo_control, 16'h28BA);
    check("dma", 16'(tx_dma_req), 16'h0);
    i_dafc_slot_model.slot(0, 4'hB, 16'h0);
    check("left", tx_slot_data, 16'hA000);
    i_dafc_slot_model.slot(0, 4'hC, 16'h0);
    check("right", tx_slot_data, 16'hA001);
    wr(0, 16'h0000);
    step;
    check("flush", tx_fifo_control, 16'h4000);
  endtask
  task automatic t_error;
    wr(0, 16'h0032);
    i_dafc_slot_model.slot(0, 4'h3, 16'h0);
    check("under", 16'(tx_slot_valid), 16'h0);
    check("flag", tx_fifo_control, 16'hC032);
    wr(0, 16'h0032);
    check("kept", tx_fifo_control, 16'hC032);
    wr(0, 16'h8030);
    check("clear", tx_fifo_control, 16'h4030);
    i_dafc_slot_model.slot(0, 4'h3, 16'h0);
    check("off", tx_fifo_control, 16'h4030);
  endtask
  // Ninth word finds the receive side full; the drain then checks order.
  task automatic t_rx;
    int n = 0;
    wr(1, 16'h0F52);
    for (int i = 0; i < 9; i++)
    begin
      check("rx irq", 16'(rx_irq), 16'(i == 8));
      i_dafc_slot_model.slot(1, 4'h5, 16'hB000 + 16'(i));
    end
    check("rx view", rx_fifo_control, 16'hAF52);
    check("rx dma", 16'(rx_dma_req), 16'h1);
    rx_data_ready = 1;
    // The word shown now is taken at the coming edge, so look before stepping.
    repeat (30)
    begin
      if (rx_data_valid === 1'b1 && n < 8)
      begin
        check("rx data", rx_data, 16'hB000 + 16'(n));
        n++;
      end
      step;
    end
    rx_data_ready = 0;
    check("rx count", 16'(n), 16'h0008);
    check("rx view", rx_fifo_control, 16'hCF52);
  endtask
  task automatic results;
    $display("%0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence.
  initial
  begin
    {srst, tx_ctrl_wr, rx_ctrl_wr, tx_data_valid, rx_data_ready} = 5'h10;
    ctrl_wdata = 16'h0000;
    tx_data = 16'h0000;
    repeat (8) @(posedge clk);
    #1;
    srst = 0;
    t_mono;
    $display("mono done");
    t_stereo;
    $display("stereo done");
    t_error;
    $display("error flags done");
    t_rx;
    $display("receive done");
    results;
  end
  // Watchdog, far beyond the hundred or so cycles the tests need.
  initial
  begin
    #40000;
    errors++;
    results;
  end
endmodule // dafc_link_fifo_tb
